// file: smr_receiver.sv
// smr_receiver: smart-card UART receiver with APB registers and open-drain error signal
`default_nettype none
`timescale 1ns/10ps
// Overview of operation
// - receive only with transmit and receive enabled
// - start bit, data LSB first (MSB first in inverse format), stop bits
// - after stop bits, or after the error signal, copy shift into buffer
// - buffer load sets complete flag and interrupt
// - reading receive buffer clears complete flag
// - parity error pulls transmit pin low
// - bit clock is source over divisor+1, sixteen
module smr_receiver #(
  parameter int DATA_BITS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_rx_pin,
  input wire logic ext_transfer_clock_pin,
  input wire logic timer_underflow,
  output logic serial_tx_pin_o,
  output logic serial_tx_pin_oe,
  output logic irq
);
  if (DATA_BITS < 7 || DATA_BITS > 9) begin : g_bad_width
    $error("DATA_BITS must be 7 to 9");
  end

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_START = 6'h02,
    ST_DATA = 6'h04,
    ST_PARITY = 6'h08,
    ST_STOP = 6'h10,
    ST_ERRSIG = 6'h20
  } smr_state_e;

  // ***************************************
  // declarations
  // ***************************************
  logic [smr_pkg::CTRL_W-1:0] ctrl_q;
  logic [7:0] brg_q;
  logic [DATA_BITS-1:0] rxbuf_q;
  logic rxperr_q;
  logic complete_q;
  logic [smr_pkg::IRQ_W-1:0] stat_q;
  logic [smr_pkg::IRQ_W-1:0] mask_q;
  logic [31:0] prdata_q;
  smr_state_e st_q;
  smr_state_e st_d;
  logic [3:0] os_q;
  logic [3:0] bit_q;
  logic stop_q;
  logic par_q;
  logic perr_q;
  logic [DATA_BITS-1:0] shift_q;
  logic rx_sync;
  logic clk_sync;
  logic tick16;

  // ***************************************
  // pin synchronisers and bit clock
  // ***************************************
  smr_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_i({serial_rx_pin, ext_transfer_clock_pin}),
    .sync_o({rx_sync, clk_sync})
  );

  smr_baudgen u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .src_sel(ctrl_q[smr_pkg::CTRL_SRC_LO +: 2]),
    .ext_sel(ctrl_q[smr_pkg::CTRL_EXT_CLK]),
    .ext_clk_sync(clk_sync),
    .timer_underflow(timer_underflow),
    .brg(brg_q),
    .tick16(tick16)
  );

  // ***************************************
  // APB decode
  // ***************************************
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_ctrl = (paddr == smr_pkg::ADDR_CTRL);
  wire hit_brg = (paddr == smr_pkg::ADDR_BRG);
  wire hit_rxbuf = (paddr == smr_pkg::ADDR_RXBUF);
  wire hit_status = (paddr == smr_pkg::ADDR_STATUS);
  wire hit_istat = (paddr == smr_pkg::ADDR_IRQ_STAT);
  wire hit_imask = (paddr == smr_pkg::ADDR_IRQ_MASK);
  wire hit_any = hit_ctrl || hit_brg || hit_rxbuf || hit_status || hit_istat || hit_imask;
  wire rd_rxbuf = rd && hit_rxbuf;

  assign pready = 1'b1;
  assign pslverr = acc && !hit_any;
  assign prdata = prdata_q;

  wire en_ok = ctrl_q[smr_pkg::CTRL_TX_EN] && ctrl_q[smr_pkg::CTRL_RX_EN];
  wire inverse = ctrl_q[smr_pkg::CTRL_INVERSE];
  wire par_en = ctrl_q[smr_pkg::CTRL_PAR_EN];
  wire par_odd = ctrl_q[smr_pkg::CTRL_PAR_ODD];
  wire stop2 = ctrl_q[smr_pkg::CTRL_STOP2];
  wire err_en = ctrl_q[smr_pkg::CTRL_ERR_EN];

  wire [31:0] rd_mux =
    hit_ctrl ? 32'(ctrl_q) :
    hit_brg ? 32'(brg_q) :
    hit_rxbuf ? (32'(rxbuf_q) | (32'(rxperr_q) << smr_pkg::RXBUF_PERR)) :
    hit_status ? 32'({(st_q != ST_IDLE), complete_q}) :
    hit_istat ? 32'(stat_q) :
    hit_imask ? 32'(mask_q) : 32'h0000_0000;

  // ***************************************
  // frame sequencer
  // ***************************************
  wire bit_l = rx_sync ^ inverse;
  wire sample = tick16 && (os_q == 4'hF);
  wire half = tick16 && (os_q == 4'(smr_pkg::HALF_BIT_TICKS - 1));
  wire last_data = (bit_q == 4'(DATA_BITS - 1));
  wire par_bad = par_q ^ bit_l ^ par_odd;
  wire last_stop = !stop2 || stop_q;
  wire frame_done = sample && ((st_q == ST_STOP && last_stop) || st_q == ST_ERRSIG);

  // direct: LSB first; inverse: MSB first
  wire [DATA_BITS-1:0] shift_nx = inverse ? {shift_q[DATA_BITS-2:0], bit_l} : {bit_l, shift_q[DATA_BITS-1:1]};

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (en_ok && !rx_sync) begin
          st_d = ST_START;
        end
      end
      ST_START: begin
        if (half) begin
          st_d = rx_sync ? ST_IDLE : ST_DATA;
        end
      end
      ST_DATA: begin
        if (sample && last_data) begin
          st_d = par_en ? ST_PARITY : ST_STOP;
        end
      end
      ST_PARITY: begin
        if (sample) begin
          st_d = (par_bad && err_en) ? ST_ERRSIG : ST_STOP;
        end
      end
      ST_STOP: begin
        if (sample && last_stop) begin
          st_d = ST_IDLE;
        end
      end
      ST_ERRSIG: begin
        if (sample) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (!en_ok) begin
      st_d = ST_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      os_q <= 4'h0;
    end else begin
      st_q <= st_d;
      if (st_d != st_q || st_q == ST_IDLE) begin
        os_q <= 4'h0;
      end else if (tick16) begin
        os_q <= os_q + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_q <= 4'h0;
      stop_q <= 1'b0;
      par_q <= 1'b0;
      perr_q <= 1'b0;
      shift_q <= '0;
    end else if (st_q == ST_START) begin
      bit_q <= 4'h0;
      stop_q <= 1'b0;
      par_q <= 1'b0;
      perr_q <= 1'b0;
    end else if (sample) begin
      if (st_q == ST_DATA) begin
        shift_q <= shift_nx;
        par_q <= par_q ^ bit_l;
        bit_q <= bit_q + 4'h1;
      end
      if (st_q == ST_PARITY) begin
        perr_q <= par_bad;
      end
      if (st_q == ST_STOP) begin
        stop_q <= 1'b1;
      end
    end
  end

  // open drain: only ever pulls low
  assign serial_tx_pin_o = 1'b0;
  assign serial_tx_pin_oe = (st_q == ST_ERRSIG);

  // ***************************************
  // registers and interrupt
  // ***************************************
  wire [smr_pkg::IRQ_W-1:0] ev = {frame_done && complete_q && !rd_rxbuf,
                                  frame_done && perr_q, frame_done};
  wire [smr_pkg::IRQ_W-1:0] w1c = (wr && hit_istat) ? pwdata[smr_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= smr_pkg::CTRL_RST;
      brg_q <= smr_pkg::BRG_RST;
      mask_q <= smr_pkg::MASK_RST;
      stat_q <= '0;
      prdata_q <= 32'h0000_0000;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_q <= pwdata[smr_pkg::CTRL_W-1:0];
      end
      if (wr && hit_brg) begin
        brg_q <= pwdata[7:0];
      end
      if (wr && hit_imask) begin
        mask_q <= pwdata[smr_pkg::IRQ_W-1:0];
      end
      stat_q <= (stat_q & ~w1c) | ev;
      if (psel && !penable) begin
        prdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxbuf_q <= '0;
      rxperr_q <= 1'b0;
      complete_q <= 1'b0;
    end else begin
      if (frame_done) begin
        rxbuf_q <= shift_q;
        rxperr_q <= perr_q;
        complete_q <= 1'b1;
      end else if (rd_rxbuf) begin
        complete_q <= 1'b0;
      end
    end
  end

  assign irq = |(stat_q & mask_q);

  // ***************************************
  // checks
  // ***************************************
  logic [4:0] pull_ticks_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_ticks_q <= 5'h00;
    end else if (!serial_tx_pin_oe) begin
      pull_ticks_q <= 5'h00;
    end else if (tick16) begin
      pull_ticks_q <= pull_ticks_q + 5'h01;
    end
  end

  property p_start_needs_enable;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_IDLE) ##1 (st_q == ST_START) |-> $past(en_ok);
  endproperty
  a_start_needs_enable: assert property (p_start_needs_enable) else $error("frame started while disabled");

  property p_data_count;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_DATA && sample && last_data && en_ok) |=> (st_q == ST_PARITY || st_q == ST_STOP);
  endproperty
  a_data_count: assert property (p_data_count) else $error("data phase length wrong");

  property p_buffer_load;
    @(posedge pclk) disable iff (!presetn)
    frame_done |=> (rxbuf_q == $past(shift_q)) && (rxperr_q == $past(perr_q));
  endproperty
  a_buffer_load: assert property (p_buffer_load) else $error("buffer not loaded at frame end");

  property p_done_flags;
    @(posedge pclk) disable iff (!presetn)
    frame_done |=> complete_q && stat_q[smr_pkg::IRQ_DONE];
  endproperty
  a_done_flags: assert property (p_done_flags) else $error("complete or interrupt flag not set");

  property p_read_clears;
    @(posedge pclk) disable iff (!presetn)
    (rd_rxbuf && !frame_done) |=> !complete_q;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("complete flag survived buffer read");

  property p_err_signal;
    @(posedge pclk) disable iff (!presetn)
    $rose(serial_tx_pin_oe) |-> $past(par_bad && err_en && sample) && !serial_tx_pin_o;
  endproperty
  a_err_signal: assert property (p_err_signal) else $error("error pull without parity error");

  property p_err_length;
    @(posedge pclk) disable iff (!presetn)
    $fell(serial_tx_pin_oe) && en_ok |-> (pull_ticks_q == 5'(smr_pkg::TICKS_PER_BIT));
  endproperty
  a_err_length: assert property (p_err_length) else $error("error pull not one bit long");

  property p_inverse_order;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_DATA && sample && inverse) |=> shift_q[0] == $past(bit_l);
  endproperty
  a_inverse_order: assert property (p_inverse_order) else $error("inverse format bit order wrong");
endmodule
`default_nettype wire

// file: smr_pkg.sv
// smr_pkg: register map, field positions and timing constants of the smart-card receiver
`default_nettype none
package smr_pkg;
  // ***************************************
  // register byte addresses
  // ***************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BRG = 8'h04;
  localparam logic [7:0] ADDR_RXBUF = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  // ***************************************
  // register field positions
  // ***************************************
  localparam int CTRL_W = 10;
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_INVERSE = 2;
  localparam int CTRL_EXT_CLK = 3;
  localparam int CTRL_SRC_LO = 4;
  localparam int CTRL_PAR_EN = 6;
  localparam int CTRL_PAR_ODD = 7;
  localparam int CTRL_STOP2 = 8;
  localparam int CTRL_ERR_EN = 9;
  localparam int RXBUF_PERR = 16;
  localparam int STATUS_DONE = 0;
  localparam int STATUS_BUSY = 1;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_PERR = 1;
  localparam int IRQ_OVR = 2;
  // ***************************************
  // reset values
  // ***************************************
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [7:0] BRG_RST = 8'h00;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
  // ***************************************
  // clock sources and timing
  // ***************************************
  typedef enum logic [1:0] {
    SRC_F1 = 2'h0,
    SRC_F8 = 2'h1,
    SRC_F32 = 2'h2,
    SRC_TIMER = 2'h3
  } smr_src_e;
  localparam int CLK_PERIOD_NS = 5;
  localparam int PRESCALE_F8 = 8;
  localparam int PRESCALE_F32 = 32;
  localparam int TICKS_PER_BIT = 16;
  localparam int HALF_BIT_TICKS = TICKS_PER_BIT / 2;
endpackage
`default_nettype wire

// file: smr_sync.sv
// smr_sync: two-flop synchroniser for pin levels
`default_nettype none
`timescale 1ns/10ps
module smr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule
`default_nettype wire

// file: smr_baudgen.sv
// smr_baudgen: source clock selection and bit-rate divider giving 16x ticks
`default_nettype none
`timescale 1ns/10ps
module smr_baudgen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] src_sel,
  input wire logic ext_sel,
  input wire logic ext_clk_sync,
  input wire logic timer_underflow,
  input wire logic [7:0] brg,
  output logic tick16
);
  logic [4:0] pre_q;
  logic half_q;
  logic ext_prev_q;
  logic [7:0] div_q;
  logic src_tick;
  logic int_tick;

  // ***************************************
  // source tick
  // ***************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 5'h00;
      half_q <= 1'b0;
      ext_prev_q <= 1'b1;
    end else begin
      pre_q <= pre_q + 5'h01;
      ext_prev_q <= ext_clk_sync;
      if (timer_underflow) begin
        half_q <= ~half_q;
      end
    end
  end

  always_comb begin
    unique case (smr_pkg::smr_src_e'(src_sel))
      smr_pkg::SRC_F1: int_tick = 1'b1;
      smr_pkg::SRC_F8: int_tick = (pre_q[2:0] == 3'(smr_pkg::PRESCALE_F8 - 1));
      smr_pkg::SRC_F32: int_tick = (pre_q == 5'(smr_pkg::PRESCALE_F32 - 1));
      smr_pkg::SRC_TIMER: int_tick = timer_underflow && half_q;
    endcase
  end

  // external transfer clock counts on its rising edge
  assign src_tick = ext_sel ? (ext_clk_sync && !ext_prev_q) : int_tick;

  // ***************************************
  // divide by brg+1
  // ***************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
    end else if (src_tick) begin
      div_q <= (div_q == 8'h00) ? brg : div_q - 8'h01;
    end
  end

  assign tick16 = src_tick && (div_q == 8'h00);

  // ***************************************
  // checks
  // ***************************************
  logic [8:0] gap_q;
  logic [7:0] gap_brg_q;
  logic gap_ok_q;
  wire f1_src = !ext_sel && (src_sel == smr_pkg::SRC_F1);

  // spacing measured only when the undivided clock fed both ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 9'h000;
      gap_brg_q <= 8'h00;
      gap_ok_q <= 1'b0;
    end else if (tick16) begin
      gap_q <= 9'h001;
      gap_brg_q <= brg;
      gap_ok_q <= f1_src;
    end else if (gap_q != 9'h1FF) begin
      gap_q <= gap_q + 9'h001;
    end
  end

  property p_bit_rate;
    @(posedge pclk) disable iff (!presetn)
    (tick16 && gap_ok_q && f1_src && gap_q != 9'h1FF) |-> (gap_q == 9'(gap_brg_q) + 9'h001);
  endproperty
  a_bit_rate: assert property (p_bit_rate) else $error("tick spacing not brg plus one");
endmodule
`default_nettype wire

// file: smr_card.sv
// smr_card: behavioural card model driving the shared open-drain serial line
`timescale 1ns/10ps
`default_nettype none
module smr_card (
  input wire logic pclk,
  input wire logic err_pull,
  output logic line_o
);
  logic err_seen;
  initial begin
    line_o = 1'b1;
    err_seen = 1'b0;
  end
  // hold one bit level and watch for the reader pulling the line low
  task automatic bit_out(input logic v, input int bc);
    line_o <= v;
    repeat (bc) begin
      @(posedge pclk);
      if (err_pull === 1'b1) err_seen = 1'b1;
    end
  endtask
  // inverse format sends inverted levels, most significant bit first
  task automatic send(input logic [7:0] d, input logic inv, input logic par_on, input logic par,
                      input int nstop, input int bc);
    err_seen = 1'b0;
    bit_out(1'b0, bc);
    for (int i = 0; i < 8; i++) bit_out((inv ? d[7-i] : d[i]) ^ inv, bc);
    if (par_on) bit_out(par ^ inv, bc);
    repeat (nstop) bit_out(1'b1, bc);
    line_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: smr_receiver_tb.sv
// smr_receiver_tb: self-checking bench for the smart-card receiver
`timescale 1ns/10ps
`default_nettype none
module smr_receiver_tb;
  typedef struct packed {
    logic [9:0] ctrl;
    logic [7:0] brg;
    logic [7:0] data;
    logic bad;
  } smr_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, irq;
  logic rx_line, card_line, pulled, ext_pin, tx_o, tx_oe;
  logic tmr = 1'b0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int errors, tests_run;
  int cyc = 0;
  smr_row_s rows [10] = '{'{10'h003, 8'h00, 8'hA5, 1'b0}, '{10'h007, 8'h01, 8'h3C, 1'b0},
    '{10'h043, 8'h02, 8'h81, 1'b0}, '{10'h1C3, 8'h00, 8'h7E, 1'b0}, '{10'h013, 8'h00, 8'h5A, 1'b0},
    '{10'h023, 8'h00, 8'h0F, 1'b0}, '{10'h033, 8'h00, 8'hC3, 1'b0}, '{10'h00B, 8'h00, 8'h96, 1'b0},
    '{10'h243, 8'h00, 8'h55, 1'b1}, '{10'h043, 8'h00, 8'h33, 1'b1}};

  smr_receiver #(.DATA_BITS(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_rx_pin(rx_line), .ext_transfer_clock_pin(ext_pin), .timer_underflow(tmr),
    .serial_tx_pin_o(tx_o), .serial_tx_pin_oe(tx_oe), .irq(irq));
  smr_card i_card (.pclk(pclk), .err_pull(pulled), .line_o(card_line));
  // open-drain line with pull-up: low if either party pulls
  assign rx_line = card_line & ~(tx_oe & ~tx_o);
  assign pulled = card_line & ~rx_line;

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ***************************************
  // source clocks and hang guard
  // ***************************************
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    tmr <= ~tmr;
    ext_pin <= cyc[2];
    if (cyc == 40000) begin
      errors++;
      $display("timeout at %0t", $time);
      report_and_stop();
    end
  end
  // ***************************************
  // tasks
  // ***************************************
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  function automatic int bitcyc(smr_row_s r);
    int p;
    p = (r.ctrl[5:4] == 2'h1) ? smr_pkg::PRESCALE_F8 : (r.ctrl[5:4] == 2'h2) ? smr_pkg::PRESCALE_F32 :
        (r.ctrl[5:4] == 2'h3) ? 4 : 1;
    if (r.ctrl[smr_pkg::CTRL_EXT_CLK]) p = 8;
    return p * (int'(r.brg) + 1) * smr_pkg::TICKS_PER_BIT;
  endfunction
  task frame(input logic [7:0] d, input logic [9:0] c, input logic bad, input int bc);
    i_card.send(d, c[2], c[6], ^d ^ c[7] ^ bad, c[8] ? 2 : 1, bc);
    repeat (2 * bc) @(posedge pclk);
  endtask
  task run_row(input smr_row_s r);
    int bc;
    bc = bitcyc(r);
    wr(smr_pkg::ADDR_CTRL, 32'(r.ctrl));
    wr(smr_pkg::ADDR_BRG, 32'(r.brg));
    frame(r.data, r.ctrl, r.bad, bc);
    chk(32'(irq), 32'h1);
    rdchk(smr_pkg::ADDR_STATUS, 32'h1);
    rdchk(smr_pkg::ADDR_IRQ_STAT, {29'h0, 1'b0, r.bad, 1'b1});
    rdchk(smr_pkg::ADDR_RXBUF, {15'h0, r.bad, 8'h00, r.data});
    rdchk(smr_pkg::ADDR_STATUS, 32'h0);
    chk(32'(i_card.err_seen), 32'(r.bad & r.ctrl[9]));
    wr(smr_pkg::ADDR_IRQ_STAT, 32'h7);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
  endtask
  // ***************************************
  // main sequence
  // ***************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    tests_run = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wr(smr_pkg::ADDR_IRQ_MASK, 32'h7);
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    // receive enable alone must not accept a frame
    wr(smr_pkg::ADDR_CTRL, 32'h002);
    wr(smr_pkg::ADDR_BRG, 32'h0);
    frame(8'h11, 10'h002, 1'b0, 16);
    rdchk(smr_pkg::ADDR_STATUS, 32'h0);
    rdchk(smr_pkg::ADDR_IRQ_STAT, 32'h0);
    $display("enable gating test done");
    // two frames without a buffer read: second overwrites, overrun flagged
    wr(smr_pkg::ADDR_CTRL, 32'h003);
    frame(8'h11, 10'h003, 1'b0, 16);
    frame(8'h22, 10'h003, 1'b0, 16);
    rdchk(smr_pkg::ADDR_IRQ_STAT, 32'h5);
    rdchk(smr_pkg::ADDR_RXBUF, 32'h22);
    $display("back-to-back frame test done");
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0);
    chk(32'(perr), 32'h1);
    chk(32'(pready), 32'h1);
    $display("unmapped address test done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(smr_pkg::ADDR_CTRL, 32'h0);
    rdchk(smr_pkg::ADDR_BRG, 32'h0);
    rdchk(smr_pkg::ADDR_IRQ_MASK, 32'h0);
    rdchk(smr_pkg::ADDR_STATUS, 32'h0);
    chk(32'(irq), 32'h0);
    chk(32'(tx_oe), 32'h0);
    chk(32'(tx_o), 32'h0);
    $display("reset test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
